// >>> pkg/dam_pkg.sv
// ----------------------------------------
// default memory attribute map: shared types
// ----------------------------------------
package dam_pkg;

    typedef enum logic [1:0] {DAM_NORMAL, DAM_DEVICE, DAM_STRONG} dam_mtype_t;
    typedef enum logic [1:0] {DAM_BYTE, DAM_HALF, DAM_WORD, DAM_DWORD} dam_size_t;

    // top three address bits pick the 512MB segment
    localparam logic [2:0] DAM_SEG_CODE = 3'h0;
    localparam logic [2:0] DAM_SEG_SRAM = 3'h1;
    localparam logic [2:0] DAM_SEG_PERI = 3'h2;
    localparam logic [2:0] DAM_SEG_XRAM_LO = 3'h3;
    localparam logic [2:0] DAM_SEG_XRAM_HI = 3'h4;
    localparam logic [2:0] DAM_SEG_XDEV_LO = 3'h5;
    localparam logic [2:0] DAM_SEG_XDEV_HI = 3'h6;
    // core-private bus: top twelve address bits
    localparam logic [11:0] DAM_CPB_TOP = 12'he00;

    localparam logic [31:0] DAM_BEAT_BYTES = 32'h0000_0004;
    localparam logic [3:0] DAM_STRB_BYTE = 4'h1;
    localparam logic [3:0] DAM_STRB_HALF = 4'h3;
    localparam logic [3:0] DAM_STRB_WORD = 4'hf;
    localparam int DAM_WBUF_DEPTH = 4;

    typedef struct packed {
        dam_mtype_t mtype;
        logic xn;
    } dam_attr_t;

    typedef struct packed {
        logic [31:0] addr;
        logic fetch;
        logic write;
        dam_size_t size;
        logic share;
        logic [63:0] wdata;
    } dam_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic write;
        logic fetch;
        logic [3:0] strb;
        logic [31:0] wdata;
        dam_mtype_t mtype;
        logic share;
        logic bufd;
    } dam_bus_t;

    // fixed default map over the whole 4GB space
    function automatic dam_attr_t dam_default_attr(input logic [31:0] a);
        dam_attr_t r;
        r.mtype = DAM_DEVICE;
        r.xn = 1'b1;
        if (a[31:29] == DAM_SEG_CODE || a[31:29] == DAM_SEG_SRAM ||
            a[31:29] == DAM_SEG_XRAM_LO || a[31:29] == DAM_SEG_XRAM_HI) begin
            r.mtype = DAM_NORMAL;
            r.xn = 1'b0;
        end else if (a[31:20] == DAM_CPB_TOP) begin
            r.mtype = DAM_STRONG;
        end
        return r;
    endfunction

endpackage

// >>> logic/dam_wbuf.sv
`timescale 1ns/1ps
// ----------------------------------------
// posted write buffer, registered head
// ----------------------------------------
module dam_wbuf #(
    parameter int W = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic push_in,
    input wire logic [W-1:0] push_data_in,
    input wire logic pop_in,
    output logic [W-1:0] head_out,
    output logic full_out,
    output logic empty_out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr, next_rd;
    logic [AW:0] count, next_count;
    logic [W-1:0] head, next_head;

    // depth must be a power of two so the pointers wrap by themselves
    always_comb begin
        next_wr = wr_ptr + AW'(push_in);
        next_rd = rd_ptr + AW'(pop_in);
        next_count = count + (AW+1)'(push_in) - (AW+1)'(pop_in);
        next_head = head;
        if (push_in && (count == '0 || (count == (AW+1)'(1) && pop_in))) begin
            next_head = push_data_in; // bypass into an empty head
        end else if (pop_in) begin
            next_head = mem[next_rd];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            head <= '0;
        end else begin
            wr_ptr <= next_wr;
            rd_ptr <= next_rd;
            count <= next_count;
            head <= next_head;
        end
    end

    // storage has no reset; popping the last entry loads head from an unwritten or stale slot
    always_ff @(posedge clk_in) begin
        if (push_in) begin
            mem[wr_ptr] <= push_data_in;
        end
    end

    assign head_out = head;
    assign full_out = (count == (AW+1)'(DEPTH));
    assign empty_out = (count == '0);
endmodule // dam_wbuf

// >>> logic/dam_attr_map.sv
`timescale 1ns/1ps
// Summary of operation
// R1: code segment is Normal memory, fetch and data both allowed.
// R2: SRAM segment is Normal, fetch and data allowed, holds bit-band areas.
// R3: peripheral segment is Device memory and execute-never.
// R4: core-private bus segment is Strongly-ordered and execute-never.
// R5: core-private bus range maps only core peripheral registers, nothing else.
// R6: fetches allowed from code, SRAM and external RAM segments.
// R7: software should prefer running code from the code segment.
// R8: Normal accesses may be reordered or speculated without changing results.
// R9: Device accesses keep order against Device and Strongly-ordered accesses.
// R10: Strongly-ordered accesses keep program order against everything.
// R11: Device writes may be buffered; Strongly-ordered writes never.
// R12: fetch from an execute-never region is blocked and faults.
// R13: ordered pairs: Device/strong after Device or strong, same sharing.
// R14: byte, halfword, word and 64-bit accesses, all little-endian.
// R15: fixed 4GB default map; enabled protection unit may override it.
// R16: external device and reserved-top segments are Device, execute-never.
module dam_attr_map (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic req_valid_in,
    input wire dam_pkg::dam_req_t req_in,
    output logic req_ready_out,
    input wire logic rpu_en_in,
    input wire logic rpu_hit_in,
    input wire dam_pkg::dam_attr_t rpu_attr_in,
    output dam_pkg::dam_bus_t bus_out,
    input wire logic bus_ready_in,
    input wire logic [31:0] bus_rdata_in,
    output logic rsp_valid_out,
    output logic [63:0] rsp_data_out,
    output logic fault_out,
    output logic [31:0] fault_addr_out
);
    import dam_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ISSUE} dam_state_t;

    dam_state_t state, next_state;
    dam_req_t cur, next_cur;
    dam_attr_t cur_attr, next_cur_attr, attr;
    logic beat, next_beat, launched, next_launched;
    dam_bus_t bus_q, next_bus, push_data, head;
    logic src_buf, next_src_buf;
    logic ready, next_ready, rsp_valid, next_rsp_valid, fault, next_fault;
    logic [63:0] rsp_data, next_rsp_data;
    logic [31:0] fault_addr, next_fault_addr;
    logic take, ovr, push, pop, buf_full, buf_empty;
    logic slot_free, direct_done, buf_busy;

    // ----------------------------------------
    // beat builder
    // ----------------------------------------
    // lanes follow little-endian byte numbering; a 64-bit access is two
    // word beats, low word at the lower address first
    function automatic dam_bus_t make_beat(input dam_req_t r, input dam_attr_t a,
                                           input logic hi);
        dam_bus_t b;
        b.valid = 1'b1;
        b.addr = hi ? r.addr + DAM_BEAT_BYTES : r.addr;
        b.write = r.write;
        b.fetch = r.fetch;
        b.mtype = a.mtype;
        b.share = r.share;
        b.bufd = 1'b0;
        case (r.size)
            DAM_BYTE: begin
                b.strb = DAM_STRB_BYTE << r.addr[1:0]; // R14
                b.wdata = {4{r.wdata[7:0]}};
            end
            DAM_HALF: begin
                b.strb = DAM_STRB_HALF << {r.addr[1], 1'b0}; // R14
                b.wdata = {2{r.wdata[15:0]}};
            end
            default: begin
                b.strb = DAM_STRB_WORD;
                b.wdata = hi ? r.wdata[63:32] : r.wdata[31:0]; // R14
            end
        endcase
        return b;
    endfunction

    // ----------------------------------------
    // attribute lookup
    // ----------------------------------------
    // protection unit wins only while it is enabled and claims the address
    always_comb begin
        ovr = rpu_en_in && rpu_hit_in;
        attr = ovr ? rpu_attr_in : dam_default_attr(req_in.addr); // R15 R1 R2 R3 R4 R16 R5 R6
        take = req_valid_in && ready;
        slot_free = !bus_q.valid || bus_ready_in;
        direct_done = bus_q.valid && bus_ready_in && !src_buf;
        // posted writes count until the bus has taken them
        buf_busy = !buf_empty || (bus_q.valid && src_buf);
        push_data = make_beat(req_in, attr, 1'b0);
        push_data.bufd = 1'b1;
    end

    // ----------------------------------------
    // access sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_cur_attr = cur_attr;
        next_beat = beat;
        next_launched = launched;
        next_ready = ready;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        next_fault = 1'b0;
        next_fault_addr = fault_addr;
        push = 1'b0;
        case (state)
            ST_IDLE: begin
                if (take) begin
                    if (req_in.fetch && attr.xn) begin
                        next_fault = 1'b1; // R12
                        next_fault_addr = req_in.addr;
                    end else if (req_in.write && attr.mtype == DAM_DEVICE &&
                                 req_in.size != DAM_DWORD && !buf_full) begin
                        push = 1'b1; // R11
                        next_rsp_valid = 1'b1;
                    end else begin
                        next_cur = req_in;
                        next_cur_attr = attr;
                        next_beat = 1'b0;
                        next_launched = 1'b0;
                        next_ready = 1'b0;
                        // normal may pass posted writes; others drain first
                        next_state = (attr.mtype == DAM_NORMAL) ? ST_ISSUE : ST_WAIT; // R8 R9
                    end
                end
            end
            ST_WAIT: begin
                if (!buf_busy) begin
                    next_state = ST_ISSUE; // R10 R13
                end
            end
            ST_ISSUE: begin
                if (direct_done) begin
                    if (cur.size == DAM_DWORD && !beat) begin
                        next_beat = 1'b1;
                        next_launched = 1'b0;
                        next_rsp_data = {32'h0000_0000, bus_rdata_in};
                    end else begin
                        if (beat) begin
                            next_rsp_data = {bus_rdata_in, rsp_data[31:0]};
                        end else begin
                            next_rsp_data = {32'h0000_0000, bus_rdata_in};
                        end
                        next_rsp_valid = 1'b1;
                        next_ready = 1'b1;
                        next_state = ST_IDLE;
                    end
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // bus slot: direct beat first, then posted writes
    // ----------------------------------------
    always_comb begin
        next_bus = bus_q;
        next_src_buf = src_buf;
        pop = 1'b0;
        if (slot_free) begin
            if (state == ST_ISSUE && !launched && !direct_done) begin
                next_bus = make_beat(cur, cur_attr, beat); // R10 R11
                next_src_buf = 1'b0;
            end else if (!buf_empty) begin
                next_bus = head;
                next_src_buf = 1'b1;
                pop = 1'b1;
            end else begin
                next_bus = '0;
                next_src_buf = 1'b0;
            end
        end
    end

    // launched tracks whether the current beat left; set as it is loaded
    logic next_launched_q;
    always_comb begin
        next_launched_q = next_launched;
        if (slot_free && state == ST_ISSUE && !launched && !direct_done) begin
            next_launched_q = 1'b1;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= ST_IDLE;
            cur <= '0;
            cur_attr <= '0;
            beat <= 1'b0;
            launched <= 1'b0;
            bus_q <= '0;
            src_buf <= 1'b0;
            ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_data <= '0;
            fault <= 1'b0;
            fault_addr <= '0;
        end else begin
            state <= next_state;
            cur <= next_cur;
            cur_attr <= next_cur_attr;
            beat <= next_beat;
            launched <= next_launched_q;
            bus_q <= next_bus;
            src_buf <= next_src_buf;
            ready <= next_ready;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            fault <= next_fault;
            fault_addr <= next_fault_addr;
        end
    end

    dam_wbuf #(
        .W($bits(dam_bus_t)),
        .DEPTH(DAM_WBUF_DEPTH)
    ) u_wbuf (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .push_in(push),
        .push_data_in(push_data),
        .pop_in(pop),
        .head_out(head),
        .full_out(buf_full),
        .empty_out(buf_empty)
    );

    assign req_ready_out = ready;
    assign bus_out = bus_q;
    assign rsp_valid_out = rsp_valid;
    assign rsp_data_out = rsp_data;
    assign fault_out = fault;
    assign fault_addr_out = fault_addr;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_code_normal: assert property (@(posedge clk_in) disable iff (rst_in) // R1
        take && !ovr && req_in.addr[31:29] == DAM_SEG_CODE |->
        attr == dam_attr_t'{DAM_NORMAL, 1'b0})
        else $error("code segment not normal executable");
    a_sram_normal: assert property (@(posedge clk_in) disable iff (rst_in) // R2
        take && !ovr && req_in.addr[31:29] == DAM_SEG_SRAM |->
        attr == dam_attr_t'{DAM_NORMAL, 1'b0})
        else $error("sram segment not normal executable");
    a_peri_device: assert property (@(posedge clk_in) disable iff (rst_in) // R3
        take && !ovr && req_in.addr[31:29] == DAM_SEG_PERI |->
        attr == dam_attr_t'{DAM_DEVICE, 1'b1})
        else $error("peripheral segment not device xn");
    a_cpb_strong: assert property (@(posedge clk_in) disable iff (rst_in) // R4
        take && !ovr && req_in.addr[31:20] == DAM_CPB_TOP |->
        attr == dam_attr_t'{DAM_STRONG, 1'b1})
        else $error("core-private range not strongly ordered");
    a_xdev_device: assert property (@(posedge clk_in) disable iff (rst_in) // R16
        take && !ovr && (req_in.addr[31:29] == DAM_SEG_XDEV_LO ||
        req_in.addr[31:29] == DAM_SEG_XDEV_HI) |-> attr == dam_attr_t'{DAM_DEVICE, 1'b1})
        else $error("external device segment not device xn");
    a_fetch_ok: assert property (@(posedge clk_in) disable iff (rst_in) // R6
        take && !ovr && req_in.fetch && (req_in.addr[31:29] == DAM_SEG_CODE ||
        req_in.addr[31:29] == DAM_SEG_SRAM || req_in.addr[31:29] == DAM_SEG_XRAM_LO ||
        req_in.addr[31:29] == DAM_SEG_XRAM_HI) |=> !fault_out ##1 !ready [*1])
        else $error("fetch from executable segment refused");
    a_xn_fault: assert property (@(posedge clk_in) disable iff (rst_in) // R12
        take && req_in.fetch && attr.xn |=> fault_out && fault_addr_out == $past(req_in.addr)
        && state == ST_IDLE && !bus_q.fetch)
        else $error("xn fetch not faulted");
    a_strong_unbuf: assert property (@(posedge clk_in) disable iff (rst_in) // R11
        push |-> push_data.mtype == DAM_DEVICE && push_data.write && !buf_full)
        else $error("non-device write posted");
    a_order_drain: assert property (@(posedge clk_in) disable iff (rst_in) // R9 R10 R13
        bus_q.valid && !src_buf && bus_q.mtype != DAM_NORMAL |-> buf_empty)
        else $error("ordered access overtook posted write");
    a_dword_pair: assert property (@(posedge clk_in) disable iff (rst_in) // R14
        direct_done && cur.size == DAM_DWORD && !beat |=> ##[1:2] bus_q.valid &&
        bus_q.addr == cur.addr + DAM_BEAT_BYTES)
        else $error("second word of 64-bit access missing");
endmodule // dam_attr_map

// >>> sim/dam_bus_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// system bus responder standing in for memory and peripherals
// ----------------------------------------
module dam_bus_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic stall_in,
    input wire dam_pkg::dam_bus_t bus_in,
    output logic ready_out,
    output logic [31:0] rdata_out
);
    import dam_pkg::*;

    logic [2:0] wait_cnt;

    // one-cycle ready after a random wait; longer waits while stalling
    // idle data is inverted every cycle so a late sample cannot match
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ready_out <= 1'b0;
            rdata_out <= 32'h0000_0000;
            wait_cnt <= 3'h0;
        end else if (ready_out) begin
            ready_out <= 1'b0;
            rdata_out <= ~rdata_out;
            wait_cnt <= stall_in ? 3'(($urandom % 6) + 1) : 3'($urandom % 2);
        end else if (bus_in.valid && wait_cnt == 3'h0) begin
            ready_out <= 1'b1;
            // little-endian word image derived from the address
            rdata_out <= {bus_in.addr[15:0], ~bus_in.addr[15:0]};
        end else begin
            wait_cnt <= (wait_cnt != 3'h0) ? wait_cnt - 3'h1 : 3'h0;
            rdata_out <= ~rdata_out;
        end
    end

endmodule // dam_bus_model

// >>> sim/dam_attr_map_tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------
// self-checking bench for the default attribute map
// ----------------------------------------
module dam_attr_map_tb_top;
    import dam_pkg::*;

    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic req_valid_in = 1'b0;
    dam_req_t req_in = '0;
    logic rpu_en_in = 1'b0;
    logic rpu_hit_in = 1'b0;
    dam_attr_t rpu_attr_in = '0;
    logic stall = 1'b0;
    logic req_ready_out, rsp_valid_out, fault_out, bus_ready;
    logic [31:0] bus_rdata, fault_addr_out;
    logic [63:0] rsp_data_out;
    dam_bus_t bus_out;
    dam_bus_t seen_q[$];
    int n_errors = 0;
    int check_count = 0;

    always #5 clk_in = ~clk_in;

    dam_attr_map dam_attr_map_inst (.clk_in(clk_in), .rst_in(rst_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
        .rpu_en_in(rpu_en_in), .rpu_hit_in(rpu_hit_in), .rpu_attr_in(rpu_attr_in),
        .bus_out(bus_out), .bus_ready_in(bus_ready), .bus_rdata_in(bus_rdata),
        .rsp_valid_out(rsp_valid_out), .rsp_data_out(rsp_data_out),
        .fault_out(fault_out), .fault_addr_out(fault_addr_out));

    dam_bus_model dam_bus_model_inst (.clk_in(clk_in), .rst_in(rst_in), .stall_in(stall),
        .bus_in(bus_out), .ready_out(bus_ready), .rdata_out(bus_rdata));

    // log every beat the bus accepts, in acceptance order
    always @(posedge clk_in) begin
        if (!rst_in && bus_out.valid === 1'b1 && bus_ready === 1'b1) begin
            seen_q.push_back(bus_out);
        end
    end

    // ----------------------------------------
    // expectations and checks
    // ----------------------------------------
    function automatic dam_attr_t exp_attr(input logic [31:0] a);
        case (a[31:29])
            3'h0, 3'h1, 3'h3, 3'h4: return dam_attr_t'{DAM_NORMAL, 1'b0};
            3'h7: return (a[31:20] == 12'he00) ? dam_attr_t'{DAM_STRONG, 1'b1} :
                dam_attr_t'{DAM_DEVICE, 1'b1};
            default: return dam_attr_t'{DAM_DEVICE, 1'b1};
        endcase
    endfunction

    function automatic logic [31:0] rd_of(input logic [31:0] a);
        return {a[15:0], ~a[15:0]};
    endfunction

    task automatic conclude();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bound(input int i);
        if (i >= 300) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
            conclude();
        end
    endtask

    // present one request, hold it until taken, then wait for its answer
    task automatic access(input dam_req_t r, output logic [63:0] d, output logic flt);
        int i;
        @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_in <= r;
        for (i = 0; i < 300; i++) begin
            @(negedge clk_in);
            if (req_ready_out === 1'b1) break;
        end
        bound(i);
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        d = '0;
        flt = 1'b0;
        for (i = 0; i < 300; i++) begin
            @(negedge clk_in);
            if (rsp_valid_out === 1'b1 || fault_out === 1'b1) break;
        end
        bound(i);
        d = rsp_data_out;
        flt = fault_out;
    endtask

    task automatic mkreq(output dam_req_t r, input logic [31:0] a, input logic f,
                         input logic w, input dam_size_t s, input logic [63:0] wd);
        r = '0;
        r.addr = a;
        r.fetch = f;
        r.write = w;
        r.size = s;
        r.share = a[4];
        r.wdata = wd;
    endtask

    // word read or fetch; checks type, data or fault against the map
    task automatic probe(input logic [31:0] a, input logic f, input dam_attr_t e);
        dam_req_t r;
        logic [63:0] d;
        logic flt;
        mkreq(r, a, f, 1'b0, DAM_WORD, '0);
        seen_q.delete();
        access(r, d, flt);
        if (f && e.xn) begin
            chk(flt, 1'b1);
            chk(fault_addr_out, a);
            chk(64'(seen_q.size()), 64'h0);
        end else begin
            chk(flt, 1'b0);
            chk(seen_q[0].mtype, e.mtype);
            chk(seen_q[0].fetch, f);
            chk(seen_q[0].addr, a);
            chk(seen_q[0].share, a[4]);
            chk(d, {32'h0000_0000, rd_of(a)});
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    logic [31:0] tbl[13] = '{32'h0000_0000, 32'h1fff_fffc, 32'h2000_0000, 32'h3fff_fffc,
        32'h4000_0000, 32'h5fff_fffc, 32'h6000_0000, 32'h9fff_fffc, 32'ha000_0000,
        32'hdfff_fffc, 32'he00f_fffc, 32'he010_0000, 32'hffff_fffc};

    initial begin
        dam_req_t r;
        logic [63:0] d;
        logic flt;
        logic [31:0] a;
        void'($urandom(83));
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        // segment edges, data then fetch
        for (int k = 0; k < 13; k++) begin
            probe(tbl[k], 1'b0, exp_attr(tbl[k]));
            probe(tbl[k], 1'b1, exp_attr(tbl[k]));
        end
        $display("test map_edges done");
        // random addresses, random fetch, with the bus stalling at times
        for (int k = 0; k < 40; k++) begin
            a = {$urandom} & 32'hffff_fffc;
            @(posedge clk_in);
            stall <= k[0];
            probe(a, 1'($urandom), exp_attr(a));
        end
        @(posedge clk_in);
        stall <= 1'b0;
        $display("test random_map done");
        // protection unit override and its miss
        @(posedge clk_in);
        rpu_en_in <= 1'b1;
        rpu_hit_in <= 1'b1;
        rpu_attr_in <= '{DAM_DEVICE, 1'b1};
        probe(32'h0000_0100, 1'b1, '{DAM_DEVICE, 1'b1});
        probe(32'h2000_0100, 1'b0, '{DAM_DEVICE, 1'b1});
        @(posedge clk_in);
        rpu_hit_in <= 1'b0;
        probe(32'h0000_0100, 1'b1, '{DAM_NORMAL, 1'b0});
        @(posedge clk_in);
        rpu_en_in <= 1'b0;
        $display("test override done");
        // strongly-ordered byte, halfword and word writes reach the bus before completing
        for (int k = 0; k < 3; k++) begin
            mkreq(r, 32'he000_e000 + 32'(k + 1), 1'b0, 1'b1, dam_size_t'(k), 64'h1234_56a5);
            seen_q.delete();
            access(r, d, flt);
            chk(64'(seen_q.size()), 64'h1);
            chk(seen_q[0].bufd, 1'b0);
            chk(seen_q[0].strb, (k == 0) ? 4'h2 : (k == 1) ? 4'hc : 4'hf);
            chk(seen_q[0].wdata, (k == 0) ? 32'ha5a5_a5a5 :
                (k == 1) ? 32'h56a5_56a5 : 32'h1234_56a5);
        end
        // dword write and read split into two little-endian beats
        mkreq(r, 32'h2000_0008, 1'b0, 1'b1, DAM_DWORD, 64'h1111_2222_3333_4444);
        seen_q.delete();
        access(r, d, flt);
        chk(seen_q[0].wdata, 32'h3333_4444);
        chk(seen_q[1].addr, 32'h2000_000c);
        chk(seen_q[1].wdata, 32'h1111_2222);
        mkreq(r, 32'h2000_0010, 1'b0, 1'b0, DAM_DWORD, '0);
        access(r, d, flt);
        chk(d, {rd_of(32'h2000_0014), rd_of(32'h2000_0010)});
        $display("test sizes done");
        // posted device writes past buffer depth, then a strongly-ordered read
        @(posedge clk_in);
        stall <= 1'b1;
        seen_q.delete();
        for (int k = 0; k < 6; k++) begin
            mkreq(r, 32'h4000_0000 + 32'(k * 16), 1'b0, 1'b1, DAM_WORD, 64'(k));
            access(r, d, flt);
        end
        mkreq(r, 32'he000_e010, 1'b0, 1'b0, DAM_WORD, '0);
        access(r, d, flt);
        @(posedge clk_in);
        stall <= 1'b0;
        chk(64'(seen_q.size()), 64'h7);
        chk(seen_q[0].bufd, 1'b1);
        for (int k = 0; k < 6; k++) begin
            chk(seen_q[k].addr, 32'h4000_0000 + 32'(k * 16));
            chk(seen_q[k].mtype, DAM_DEVICE);
        end
        chk(seen_q[6].addr, 32'he000_e010);
        chk(d, {32'h0000_0000, rd_of(32'he000_e010)});
        $display("test ordering done");
        conclude();
    end

endmodule // dam_attr_map_tb_top
